// *** shared/sep_defs.svh ***
/*
  Constants of the serial EEPROM pin interface: encodings, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Summary of operation
// [R01] Device is selected only while the active-low select pin is low.
// [R02] While deselected, serial input bits are ignored and nothing is accepted.
// [R03] While deselected, the serial output stays undriven.
// [R04] Host must assert select once after power-up before any sequence counts.
// [R05] Output bits change after each falling serial clock edge during a read.
// [R06] Input bits are captured on each rising serial clock edge.
// [R07] Clock modes idle-low and idle-high both supported, sampling on rising edges.
// [R08] Protect pin high leaves reads and writes unprotected by that pin.
// [R09] Protect pin low with enable bit set refuses every status write.
// [R10] Protect pin falling while selected aborts a pending protected status write.
// [R11] A started status write cycle completes regardless of the protect pin.
// [R12] Enable bit clear makes the device ignore the protect pin entirely.
// [R13] Block protection covers a quarter, a half or all of the array.
// [R14] Each self-timed write cycle finishes within the maximum time unaided.
// [R15] Pause pin low while clock low freezes the serial sequence state.
// [R16] Pause pin returns high while clock low; paused edges never advance state.
// [R17] While paused, output floats and serial input is ignored.
// [R18] Bytes move MSB first in groups of eight; counter clears on select rise.
// [R19] In idle-high mode the leading falling edge after select is ignored.
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// Instruction codes
`define SEP_OP_WR_STATUS      8'h01
`define SEP_OP_RD_STATUS      8'h05

// Status word field positions
`define SEP_ST_PROTECT_PIN_ENABLE_BIT_BIT       7
`define SEP_ST_BP_HI          3
`define SEP_ST_BP_LO          2
`define SEP_ST_BUSY_BIT       0

// Reset value and block protection encodings
`define SEP_ST_RESET          8'h00
`define SEP_BP_NONE           2'h0
`define SEP_BP_QUARTER        2'h1
`define SEP_BP_HALF           2'h2
`define SEP_BP_ALL            2'h3
`define SEP_TOP_QUARTER       2'h3

// Serial framing
`define SEP_BIT_LAST          3'h7
`define SEP_BYTE_OPCODE       2'h0
`define SEP_BYTE_FIRST_DATA   2'h1
`define SEP_BYTE_SAT          2'h3

// Timing: write cycle maximum in ms, system clock period in ns
`define SEP_T_WR_MS           5
`define SEP_NS_PER_MS         1_000_000
`define SEP_CLK_PERIOD_NS     4
`define SEP_WR_CYCLES         ((`SEP_T_WR_MS * `SEP_NS_PER_MS) / `SEP_CLK_PERIOD_NS)

`endif

// *** shared/sep_pkg.sv ***
/*
  Types of the serial EEPROM pin interface.
  Assumes sep_defs.svh is on the include path.
*/
`include "sep_defs.svh"

package sep_pkg;

    typedef struct packed {
        logic       protect_pin_enable_bit;
        logic [2:0] rsvd;
        logic [1:0] bp;
        logic       rsvd0;
        logic       busy;
    } sep_status_t;

    typedef struct packed {
        logic       refused;
        logic       aborted;
        logic       done;
    } sep_wr_evt_t;

    typedef enum logic [2:0] {
        SEP_IDLE  = 3'b001,
        SEP_PEND  = 3'b010,
        SEP_WRITE = 3'b100
    } sep_wr_state_t;

endpackage

// *** core/sep_sync.sv ***
/*
  Two-flop level synchroniser, WIDTH bits, each bit crossed on its own.
  Assumes each bit is a slow level; multi-bit words must be quasi-static.
*/
`timescale 1ns/1ps
`default_nettype none

module sep_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("sep_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// *** core/sep_top.sv ***
/*
  Pin-level slave interface of a serial EEPROM: select, capture and shift,
  pause, status register write with pin write protection, block protection
  decode and the self-timed write cycle.
  Assumes the host drives sck, cs_n, si and hold_n; sck may stop outside
  frames. wp_n is an asynchronous pin. ref_clk runs at 250 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sep_defs.svh"

module sep_top #(
    parameter int unsigned WR_CYCLES = `SEP_WR_CYCLES,
    parameter int unsigned ADDR_TOP  = 2
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    input  wire logic                  sck,
    input  wire logic                  cs_n,
    input  wire logic                  si,
    input  wire logic                  hold_n,
    input  wire logic                  wp_n,
    input  wire logic [ADDR_TOP-1:0]   array_addr_top,
    output logic                       so_o,
    output logic                       so_oe_n,
    output sep_pkg::sep_status_t       status,
    output logic                       busy,
    output logic                       selected,
    output logic                       paused,
    output logic [7:0]                 cmd_opcode,
    output logic                       cmd_strobe,
    output sep_pkg::sep_wr_evt_t       wr_evt,
    output logic [1:0]                 prot_range,
    output logic                       array_wr_blocked
);
    import sep_pkg::*;

    localparam int TW = (WR_CYCLES > 1) ? $clog2(WR_CYCLES) : 1;

    initial begin
        if (WR_CYCLES < 1) begin
            $error("sep_top: WR_CYCLES must be at least 1");
        end
        if (ADDR_TOP != 2) begin
            $error("sep_top: ADDR_TOP must be 2 for quarter decode");
        end
    end

    // Link domain: runs on sck; control flops cleared asynchronously while deselected

    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [6:0] rx_sh;
    logic [7:0] opcode;
    logic       op_valid;
    logic       seen_rise;
    logic       wr_req;
    logic [7:0] wr_data;
    logic [7:0] rx_next;
    logic       byte_done;
    logic       float_async;
    logic [7:0] st_link;

    assign rx_next   = {rx_sh, si};                                   // [R18]
    assign byte_done = (bit_cnt == `SEP_BIT_LAST);

    // Select high holds the counters and shift register cleared, so input is never taken
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin                                               // [R01] [R02]
            bit_cnt   <= '0;                                          // [R18]
            byte_cnt  <= `SEP_BYTE_OPCODE;
            rx_sh     <= '0;
        end else if (hold_n) begin                                    // [R15] [R16] [R17]
            bit_cnt <= bit_cnt + 3'h1;                                // [R06]
            rx_sh   <= rx_next[6:0];
            if (byte_done && byte_cnt != `SEP_BYTE_SAT) begin
                byte_cnt <= byte_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            opcode   <= '0;
            op_valid <= 1'b0;
        end else if (hold_n && byte_done && byte_cnt == `SEP_BYTE_OPCODE) begin
            opcode   <= rx_next;                                      // [R06]
            op_valid <= 1'b1;
        end
    end

    // Mode 3 starts with sck high; the first falling edge precedes any rise
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            seen_rise <= 1'b0;
        end else if (hold_n) begin
            seen_rise <= 1'b1;                                        // [R07] [R19]
        end
    end

    // Request level holds until select rises, which commits the write
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            wr_req <= 1'b0;
        end else if (hold_n && byte_done && byte_cnt == `SEP_BYTE_FIRST_DATA
                     && op_valid && opcode == `SEP_OP_WR_STATUS) begin
            wr_req <= 1'b1;
        end
    end

    // Data word, not control: only read after wr_req is seen in ref_clk
    always_ff @(posedge sck) begin
        if (!cs_n && hold_n && byte_done && byte_cnt == `SEP_BYTE_FIRST_DATA
            && op_valid && opcode == `SEP_OP_WR_STATUS) begin
            wr_data <= rx_next;
        end
    end

    sep_sync #(
        .WIDTH     (8),
        .RESET_VAL (`SEP_ST_RESET)
    ) u_st_sync (
        .clk  (sck),
        .srst (1'b0),
        .ce   (1'b1),
        .d    (status),
        .q    (st_link)
    );

    logic       drv_q;

    assign float_async = cs_n | ~hold_n;

    // Bit and drive state survive a pause, so the line returns on resume
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_o  <= 1'b0;
            drv_q <= 1'b0;                                            // [R03]
        end else if (hold_n) begin                                    // [R16]
            if (seen_rise && op_valid
                && opcode == `SEP_OP_RD_STATUS) begin                 // [R19]
                drv_q <= 1'b1;
                so_o  <= st_link[`SEP_BIT_LAST - bit_cnt];            // [R05] [R18]
            end else begin
                drv_q <= 1'b0;
                so_o  <= 1'b0;
            end
        end
    end

    // Pause or deselect floats SO at once, not at the next clock edge
    assign so_oe_n = float_async | ~drv_q;                            // [R03] [R17]

    // System domain

    logic          cs_s;
    logic          wp_s;
    logic          req_s;
    logic          opv_s;
    logic          hold_s;
    logic          req_d;
    logic          opv_d;
    logic          armed;
    logic          req_rise;
    logic          protect_on;
    logic [7:0]    pend_data;
    logic [TW-1:0] timer;
    sep_wr_state_t state;

    sep_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h19)
    ) u_pin_sync (
        .clk  (ref_clk),
        .srst (srst),
        .ce   (ce),
        .d    ({cs_n, wp_n, wr_req, op_valid, hold_n}),
        .q    ({cs_s, wp_s, req_s, opv_s, hold_s})
    );

    assign req_rise   = req_s & ~req_d;
    // Pin counts only when the enable bit is set
    assign protect_on = status.protect_pin_enable_bit & ~wp_s;                          // [R08] [R09] [R12]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_d <= 1'b0;
            opv_d <= 1'b0;
        end else if (ce) begin
            req_d <= req_s;
            opv_d <= opv_s;
        end
    end

    // No sequence counts until select has been seen low once
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            armed <= 1'b0;
        end else if (ce && !cs_s) begin
            armed <= 1'b1;                                            // [R04]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            selected <= 1'b0;
            paused   <= 1'b0;
        end else if (ce) begin
            selected <= ~cs_s;                                        // [R01]
            paused   <= ~cs_s & ~hold_s;
        end
    end

    // Opcode is stable from op_valid until select rises
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmd_opcode <= '0;
            cmd_strobe <= 1'b0;
        end else if (ce) begin
            cmd_strobe <= 1'b0;
            if (opv_s && !opv_d && armed) begin
                cmd_opcode <= opcode;
                cmd_strobe <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state     <= SEP_IDLE;
            pend_data <= '0;
            timer     <= '0;
            wr_evt    <= '0;
        end else if (ce) begin
            wr_evt <= '0;
            unique case (state)
                SEP_IDLE: begin
                    if (req_rise && armed) begin                      // [R04]
                        if (protect_on) begin
                            wr_evt.refused <= 1'b1;                   // [R09]
                        end else begin
                            pend_data <= wr_data;
                            state     <= SEP_PEND;
                        end
                    end
                end
                SEP_PEND: begin
                    if (protect_on) begin
                        wr_evt.aborted <= 1'b1;                       // [R10]
                        state          <= SEP_IDLE;
                    end else if (cs_s) begin
                        timer <= TW'(WR_CYCLES - 1);                  // [R14]
                        state <= SEP_WRITE;
                    end
                end
                SEP_WRITE: begin
                    // Protect pin is not looked at once the cycle runs
                    if (timer == '0) begin                            // [R11] [R14]
                        wr_evt.done <= 1'b1;
                        state       <= SEP_IDLE;
                    end else begin
                        timer <= timer - TW'(1);
                    end
                end
                default: begin
                    state <= SEP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status <= `SEP_ST_RESET;
        end else if (ce) begin
            status.busy <= (state == SEP_WRITE) && (timer != '0);
            if (state == SEP_WRITE && timer == '0) begin              // [R11]
                status.protect_pin_enable_bit <= pend_data[`SEP_ST_PROTECT_PIN_ENABLE_BIT_BIT];
                status.bp   <= pend_data[`SEP_ST_BP_HI:`SEP_ST_BP_LO];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= (state == SEP_WRITE) && (timer != '0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prot_range       <= `SEP_BP_NONE;
            array_wr_blocked <= 1'b0;
        end else if (ce) begin
            prot_range <= status.bp;                                  // [R13]
            unique case (status.bp)
                `SEP_BP_NONE:    array_wr_blocked <= 1'b0;
                `SEP_BP_QUARTER: array_wr_blocked <= (array_addr_top == `SEP_TOP_QUARTER);
                `SEP_BP_HALF:    array_wr_blocked <= array_addr_top[ADDR_TOP-1];
                `SEP_BP_ALL:     array_wr_blocked <= 1'b1;            // [R13]
            endcase
        end
    end

endmodule

`default_nettype wire

// *** verif/sep_top_sva.sv ***
/*
  Concurrent checks on the serial EEPROM pin interface ports.
  Assumes ce is held high and a bind onto every sep_top instance.
*/
`timescale 1ns/1ps
`default_nettype none

module sep_top_sva #(
    parameter int unsigned WR_CYCLES = 20
) (
    input wire logic                 ref_clk,
    input wire logic                 srst,
    input wire logic                 sck,
    input wire logic                 cs_n,
    input wire logic                 hold_n,
    input wire logic                 so_o,
    input wire logic                 so_oe_n,
    input wire sep_pkg::sep_status_t status,
    input wire logic                 busy,
    input wire logic                 selected,
    input wire sep_pkg::sep_wr_evt_t wr_evt
);
    import sep_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [31:0] bcnt;
    // Counts the whole busy stretch so its exact length can be judged at its end
    always_ff @(posedge ref_clk) begin
        if (srst || !busy) bcnt <= 32'h0000_0000;
        else bcnt <= bcnt + 32'h0000_0001;
    end

    sequence s_float2;  so_oe_n [*2];  endsequence
    sequence s_no_cycle; !busy [*4]; endsequence

    property p_float;   cs_n |-> s_float2; endproperty
    property p_hold;    (!cs_n && !hold_n) |-> so_oe_n; endproperty
    property p_so_edge; (!so_oe_n && $changed(so_o)) |-> !sck; endproperty
    property p_sel;     $fell(cs_n) |-> ##[1:4] selected; endproperty
    property p_desel;   $rose(cs_n) |-> ##[1:4] !selected; endproperty
    property p_busy_len; $fell(busy) |-> bcnt == WR_CYCLES - 1; endproperty
    property p_done;    $fell(busy) |-> wr_evt.done; endproperty
    property p_refuse;  wr_evt.refused |-> status.protect_pin_enable_bit && !busy; endproperty
    property p_abort;   wr_evt.aborted |-> status.protect_pin_enable_bit ##1 s_no_cycle; endproperty
    property p_ignore;  !status.protect_pin_enable_bit |-> !(wr_evt.refused || wr_evt.aborted); endproperty

    a_float:    assert property (p_float) else $error("output driven while deselected");
    a_hold:     assert property (p_hold) else $error("output driven while paused");
    a_so_edge:  assert property (p_so_edge) else $error("output moved off falling clock");
    a_sel:      assert property (p_sel) else $error("select not seen");
    a_desel:    assert property (p_desel) else $error("deselect not seen");
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    a_done:     assert property (p_done) else $error("write cycle end without done");
    a_refuse:   assert property (p_refuse) else $error("refusal without enable");
    a_abort:    assert property (p_abort) else $error("abort wrong");
    a_ignore:   assert property (p_ignore) else $error("pin used with enable clear");
endmodule

bind sep_top sep_top_sva #(.WR_CYCLES(WR_CYCLES)) u_sva (
    .ref_clk, .srst, .sck, .cs_n, .hold_n, .so_o, .so_oe_n,
    .status, .busy, .selected, .wr_evt
);

`default_nettype wire

// *** verif/sep_host.sv ***
/*
  Host SPI master model: drives serial clock, select, data and pause pins.
  Assumes the caller serialises frames; serial clock stands still between them.
*/
`timescale 1ns/1ps
`default_nettype none

module sep_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so_o,
    input  wire logic so_oe_n
);
    logic cpol     = 1'b0;
    logic last     = 1'b0;
    logic pz_float = 1'b0;
    logic so_line;

    // A released line shows the inverse of its last level, never a stale copy
    always @(so_o, so_oe_n) if (!so_oe_n) last = so_o;
    assign so_line = so_oe_n ? ~last : so_o;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end

    task automatic xfer(input logic [15:0] tx, input int nb, input int pz, input bit keep,
                        output logic [7:0] rx);
        rx = 8'h00;
        sck = cpol;
        #7.5 cs_n = 1'b0;
        if (cpol) #7.5 sck = 1'b0;
        for (int i = 0; i < nb; i++) begin
            if (i == pz) begin
                hold_n = 1'b0;
                repeat (3) begin
                    #7.5 sck = 1'b1;
                    si = ~si;
                    #7.5 sck = 1'b0;
                end
                pz_float = so_oe_n;
                hold_n = 1'b1;
            end
            si = tx[15-i];
            #7.5 if (i >= 8) rx = {rx[6:0], so_line};
            sck = 1'b1;
            #7.5 sck = 1'b0;
        end
        #7.5 sck = cpol;
        if (!keep) #7.5 cs_n = 1'b1;
        si = ~si;
    endtask

    task automatic release_cs();
        #7.5 cs_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// *** verif/tb_sep_top.sv ***
/*
  Self-checking bench for the serial EEPROM pin interface.
  Assumes sep_top_sva is bound and sep_host plays the host controller.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sep_top;
    import sep_pkg::*;
    typedef struct packed {
        logic [7:0] d;
        logic       wpn;
        logic [2:0] ev;
        logic [7:0] st;
    } sep_row_t;

    logic         ref_clk  = 1'b0;
    logic         srst     = 1'b1;
    logic         wp_n     = 1'b1;
    logic [1:0]   top_a    = 2'h2;
    logic [2:0]   evs      = 3'h0;
    logic [1:0]   seen     = 2'h0;
    int           n_errors = 0;
    int           n_checks = 0;
    wire logic    sck, cs_n, si, hold_n, so_o, so_oe_n, busy, selected, paused, cmd_strobe;
    wire logic    array_wr_blocked;
    wire logic [7:0] cmd_opcode;
    wire logic [1:0] prot_range;
    sep_status_t  status;
    sep_wr_evt_t  wr_evt;
    // Done, refused, refused-then-open, bp sweep over none/quarter/half/all
    sep_row_t rows [5] = '{'{8'h8C, 1'b0, 3'h1, 8'h8C}, '{8'h04, 1'b0, 3'h4, 8'h8C},
                           '{8'h04, 1'b1, 3'h1, 8'h04}, '{8'h88, 1'b1, 3'h1, 8'h88},
                           '{8'h00, 1'b1, 3'h1, 8'h00}};

    sep_top #(.WR_CYCLES(20), .ADDR_TOP(2)) dut (
        .ref_clk, .srst, .ce(1'b1), .sck, .cs_n, .si, .hold_n, .wp_n,
        .array_addr_top(top_a), .so_o, .so_oe_n, .status, .busy, .selected, .paused,
        .cmd_opcode, .cmd_strobe, .wr_evt, .prot_range, .array_wr_blocked
    );
    sep_host host (.sck, .cs_n, .si, .hold_n, .so_o, .so_oe_n);

    initial forever #2 ref_clk = ~ref_clk;
    // Pulses are one cycle wide, so they are gathered rather than polled
    always @(posedge ref_clk) evs <= evs | wr_evt;
    always @(posedge ref_clk) seen <= seen | {paused, cmd_strobe};

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_ev(input logic [2:0] exp);
        int i;
        i = 0;
        while (evs === 3'h0 && i < 300) begin
            @(posedge ref_clk);
            i++;
        end
        if (i >= 300 && exp !== 3'h0) begin
            n_errors++;
            end_sim();
        end
        repeat (4) @(posedge ref_clk);
        #1 chk(evs, exp);
    endtask

    task automatic wr(input logic [7:0] d, input logic [2:0] ev);
        logic [7:0] rx;
        evs = 3'h0;
        host.xfer({8'h01, d}, 16, -1, 1'b0, rx);
        wait_ev(ev);
        chk(cmd_opcode, 8'h01);
    endtask

    task automatic rd(input logic [7:0] st, input int pz);
        logic [7:0] rx;
        host.xfer(16'h0500, 16, pz, 1'b0, rx);
        repeat (6) @(posedge ref_clk);
        #1 chk(rx, st);
        chk(status, st);
        chk(prot_range, st[3:2]);
        chk(array_wr_blocked, st[3]);
    endtask

    task automatic set_wp(input logic v);
        @(posedge ref_clk);
        #1 wp_n = v;
        repeat (4) @(posedge ref_clk);
    endtask

    initial begin
        int i;
        logic [7:0] rx;
        repeat (5) @(posedge ref_clk);
        #1 srst = 1'b0;
        @(posedge ref_clk);
        #1 chk(status, 8'h00);
        chk(busy, 1'b0);
        chk(selected, 1'b0);
        $display("test reset done");
        foreach (rows[k]) begin
            set_wp(rows[k].wpn);
            wr(rows[k].d, rows[k].ev);
            rd(rows[k].st, -1);
            $display("test row %0d done", k);
        end
        set_wp(1'b1);
        wr(8'h80, 3'h1);
        evs = 3'h0;
        host.xfer(16'h010C, 16, -1, 1'b1, rx);
        set_wp(1'b0);
        repeat (8) @(posedge ref_clk);
        host.release_cs();
        wait_ev(3'h2);
        rd(8'h80, -1);
        $display("test abort done");
        set_wp(1'b1);
        evs = 3'h0;
        host.xfer(16'h0184, 16, -1, 1'b0, rx);
        for (i = 0; i < 100 && busy !== 1'b1; i++) @(posedge ref_clk);
        if (i >= 100) begin
            n_errors++;
            end_sim();
        end
        #1 wp_n = 1'b0;
        wait_ev(3'h1);
        rd(8'h84, -1);
        $display("test started write done");
        rd(8'h84, 10);
        chk(host.pz_float, 1'b1);
        $display("test pause done");
        host.cpol = 1'b1;
        rd(8'h84, -1);
        host.cpol = 1'b0;
        $display("test idle-high done");
        evs = 3'h0;
        host.xfer(16'h0100, 12, -1, 1'b0, rx);
        wait_ev(3'h0);
        rd(8'h84, -1);
        $display("test partial frame done");
        chk(seen, 2'h3);
        end_sim();
    end
endmodule

`default_nettype wire
